/* File: hdl/jlc_link_control.sv */
// Link control page: APB registers and lane character stream
`timescale 1ns/1ps
// Notes on behaviour
// - Control bit clear: five frames per multiframe; set: use length register.
// - Programmed frames field means value plus one frames.
// - Pattern enable sends long transport test pattern instead of samples.
// - Flip bit reverses sample bit order.
// - Lane align bit inserts K28.3 characters.
// - Frame align bit inserts K28.7 characters.
// - Suppress bit skips initial alignment sequence after sync release.
// - Sync source: pin when select clear, software bit when set.
// - Software sync with register source replaces data by K28.5.
// - Filter field bits 5-3 with lane mode set configuration; 000 bypass.
// - Lane mode field bits 2-0 selects lanes; resets to 001, eight lanes.
// - Bypass: four lanes for modes 100/010, eight for 001.
// - Mode 001 gives four lanes for filters 110 and 111.
// - Two lanes for 110/010, 111/010, 100/001; one for 100/010.
module jlc_link_control
    import jlc_pkg::*;
#(
    parameter int SAMPLE_W = 14
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [9:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic      [31:0]         prdata,
    output logic                     pslverr,
    // Sample input and sync pin (sync request active low)
    input  wire logic [SAMPLE_W-1:0] sampleData,
    input  wire logic                syncPin_n,
    // Lane character stream
    output logic      [7:0]          laneByte,
    output logic                     laneIsK,
    output logic      [3:0]          activeLanes,
    output logic      [4:0]          framesPerMf
);
    if (SAMPLE_W < 8 || SAMPLE_W > 16) begin : g_bad_width
        $error("SAMPLE_W must be 8 to 16");
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  linkControl_reg;
    logic [7:0]  syncLane_reg;
    logic [4:0]  mfLength_reg;
    logic        wrEn;
    logic        rdEn;
    logic        addrHit;
    logic [3:0]  laneCountDec;
    logic        comboValid;
    jlc_state_e laneState_reg;

    assign wrEn    = psel && penable && pwrite;
    assign rdEn    = psel && !penable && !pwrite;
    assign addrHit = (paddr == LINK_CONTROL_ADDR) || (paddr == SYNC_LANE_ADDR)
                  || (paddr == MF_LENGTH_ADDR) || (paddr == LANE_STATUS_ADDR);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addrHit;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            linkControl_reg <= LINK_CONTROL_RST;
        end else if (wrEn && paddr == LINK_CONTROL_ADDR) begin
            // Bits 6-5 are write-zero and read back as zero
            linkControl_reg <= pwdata[7:0] & LINK_CONTROL_MASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncLane_reg <= SYNC_LANE_RST;
        end else if (wrEn && paddr == SYNC_LANE_ADDR) begin
            syncLane_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mfLength_reg <= MF_LENGTH_RST;
        end else if (wrEn && paddr == MF_LENGTH_ADDR) begin
            mfLength_reg <= pwdata[4:0];
        end
    end

    // Read data registered in setup so it stands through the access phase
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rdEn) begin
            case (paddr)
                LINK_CONTROL_ADDR: prdata <= {24'h0, linkControl_reg};
                SYNC_LANE_ADDR:    prdata <= {24'h0, syncLane_reg};
                MF_LENGTH_ADDR:    prdata <= {27'h0, mfLength_reg};
                LANE_STATUS_ADDR:  prdata <= {23'h0, comboValid,
                                              2'h0, laneState_reg,
                                              laneCountDec};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Link configuration
    // ------------------------------------------------------------------
    jlc_lane_decode u_decode (
        .filterSel  (syncLane_reg[FILTER_LSB +: 3]),
        .modeSel    (syncLane_reg[MODE_LSB +: 3]),
        .laneCount  (laneCountDec),
        .comboValid (comboValid)
    );

    logic [4:0] framesNext;
    // Field plus one; a field of 1Fh wraps to 0, and the frame counter then runs 32 frames
    assign framesNext = linkControl_reg[MF_SRC_BIT]
                      ? mfLength_reg + 5'h01
                      : DEFAULT_FRAMES;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            activeLanes <= 4'h0;
            framesPerMf <= DEFAULT_FRAMES;
        end else begin
            activeLanes <= laneCountDec;
            framesPerMf <= framesNext;
        end
    end

    // ------------------------------------------------------------------
    // Sync source and lane state
    // ------------------------------------------------------------------
    logic syncReq;
    assign syncReq = syncLane_reg[SYNC_SRC_BIT]
                   ? syncLane_reg[SW_SYNC_BIT]
                   : !syncPin_n;

    jlc_state_e laneState_next;
    logic [3:0] octetCnt_reg;
    logic [4:0] frameCnt_reg;
    logic [1:0] mfCnt_reg;
    logic       frameEnd;
    logic       mfEnd;

    // Four octets per frame on each lane
    assign frameEnd = (octetCnt_reg == 4'h3);
    assign mfEnd    = frameEnd && (frameCnt_reg == framesPerMf - 5'h01);

    always_comb begin
        laneState_next = laneState_reg;
        case (laneState_reg)
            JLC_SYNC: begin
                if (!syncReq) begin
                    laneState_next = linkControl_reg[SUPPRESS_BIT]
                                   ? JLC_DATA : JLC_ALIGN_SEQ;
                end
            end
            JLC_ALIGN_SEQ: begin
                if (syncReq)
                    laneState_next = JLC_SYNC;
                else if (mfEnd && mfCnt_reg == 2'h3)
                    laneState_next = JLC_DATA;
            end
            JLC_DATA: begin
                if (syncReq)
                    laneState_next = JLC_SYNC;
            end
            default: laneState_next = JLC_SYNC;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            laneState_reg <= JLC_SYNC;
        else
            laneState_reg <= laneState_next;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            octetCnt_reg <= 4'h0;
            frameCnt_reg <= 5'h00;
            mfCnt_reg    <= 2'h0;
        end else if (laneState_next != laneState_reg) begin
            octetCnt_reg <= 4'h0;
            frameCnt_reg <= 5'h00;
            mfCnt_reg    <= 2'h0;
        end else begin
            octetCnt_reg <= frameEnd ? 4'h0 : octetCnt_reg + 4'h1;
            if (mfEnd) begin
                frameCnt_reg <= 5'h00;
                mfCnt_reg    <= mfCnt_reg + 2'h1;
            end else if (frameEnd) begin
                frameCnt_reg <= frameCnt_reg + 5'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    function automatic logic [15:0] reverse16(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++)
            r[i] = v[15 - i];
        return r;
    endfunction

    logic [15:0] sampleWide;
    logic [15:0] sampleOut;
    logic [15:0] patternWord;
    logic [7:0]  dataByte;

    assign sampleWide = 16'(sampleData) << (16 - SAMPLE_W);
    assign sampleOut  = linkControl_reg[FLIP_BIT]
                      ? reverse16(sampleWide) : sampleWide;
    // Long transport pattern: sample slot carries frame and octet index
    assign patternWord = {3'h0, frameCnt_reg, 4'h0, octetCnt_reg};
    assign dataByte = linkControl_reg[PATTERN_BIT]
                    ? (octetCnt_reg[0] ? patternWord[7:0]
                                       : patternWord[15:8])
                    : (octetCnt_reg[0] ? sampleOut[7:0]
                                       : sampleOut[15:8]);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            laneByte <= K28_5;
            laneIsK  <= 1'b1;
        end else if (laneState_reg == JLC_SYNC) begin
            laneByte <= K28_5;
            laneIsK  <= 1'b1;
        end else if (laneState_reg == JLC_ALIGN_SEQ) begin
            laneIsK  <= frameCnt_reg == 5'h00 && octetCnt_reg == 4'h0
                     || mfEnd;
            laneByte <= (frameCnt_reg == 5'h00 && octetCnt_reg == 4'h0)
                      ? (mfCnt_reg == 2'h1 ? K28_5 : 8'h1C)
                      : (mfEnd ? K28_3 : 8'h00);
        end else if (mfEnd && linkControl_reg[LANE_ALIGN_BIT]) begin
            laneByte <= K28_3;
            laneIsK  <= 1'b1;
        end else if (frameEnd && linkControl_reg[FRAME_ALIGN_BIT]) begin
            laneByte <= K28_7;
            laneIsK  <= 1'b1;
        end else begin
            laneByte <= comboValid ? dataByte : 8'h00;
            laneIsK  <= 1'b0;
        end
    end
endmodule // jlc_link_control

/* File: hdl/jlc_pkg.sv */
// Package for the serial link control page: offsets, fields, reset values
package jlc_pkg;
    // ------------------------------------------------------------------
    // Register indices; each byte address is four times its index
    // ------------------------------------------------------------------
    localparam logic [7:0] LINK_CONTROL_IDX  = 8'h00;
    localparam logic [7:0] SYNC_LANE_IDX     = 8'h01;
    localparam logic [7:0] MF_LENGTH_IDX     = 8'h06;
    localparam logic [7:0] LANE_STATUS_IDX   = 8'h08;
    localparam logic [9:0] LINK_CONTROL_ADDR = 10'h000;
    localparam logic [9:0] SYNC_LANE_ADDR    = 10'h004;
    localparam logic [9:0] MF_LENGTH_ADDR    = 10'h018;
    localparam logic [9:0] LANE_STATUS_ADDR  = 10'h020;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MF_SRC_BIT      = 7;
    localparam int PATTERN_BIT     = 4;
    localparam int FLIP_BIT        = 3;
    localparam int LANE_ALIGN_BIT  = 2;
    localparam int FRAME_ALIGN_BIT = 1;
    localparam int SUPPRESS_BIT    = 0;
    localparam int SW_SYNC_BIT     = 7;
    localparam int SYNC_SRC_BIT    = 6;
    localparam int FILTER_LSB      = 3;
    localparam int MODE_LSB        = 0;

    // ------------------------------------------------------------------
    // Reset values and masks of writable bits
    // ------------------------------------------------------------------
    localparam logic [7:0] LINK_CONTROL_RST  = 8'h00;
    localparam logic [7:0] SYNC_LANE_RST     = 8'h01;
    localparam logic [4:0] MF_LENGTH_RST     = 5'h08;
    localparam logic [7:0] LINK_CONTROL_MASK = 8'h9F;
    localparam logic [4:0] DEFAULT_FRAMES    = 5'h05;

    // ------------------------------------------------------------------
    // Filter and lane-mode codes
    // ------------------------------------------------------------------
    localparam logic [2:0] FILT_BYPASS = 3'h0;
    localparam logic [2:0] FILT_DEC4   = 3'h4;
    localparam logic [2:0] FILT_DEC2   = 3'h6;
    localparam logic [2:0] FILT_DEC4IQ = 3'h7;
    localparam logic [2:0] MODE_ONE    = 3'h1;
    localparam logic [2:0] MODE_TWO    = 3'h2;
    localparam logic [2:0] MODE_FOUR   = 3'h4;

    // ------------------------------------------------------------------
    // Control characters (8b/10b K codes, byte values)
    // ------------------------------------------------------------------
    localparam logic [7:0] K28_3 = 8'h7C;
    localparam logic [7:0] K28_5 = 8'hBC;
    localparam logic [7:0] K28_7 = 8'hFC;

    // Lane stream states
    typedef enum logic [1:0] {
        JLC_SYNC,
        JLC_ALIGN_SEQ,
        JLC_DATA
    } jlc_state_e;
endpackage

/* File: hdl/jlc_lane_decode.sv */
// Lane-count decoder for filter and lane-mode combinations
`timescale 1ns/1ps
module jlc_lane_decode
    import jlc_pkg::*;
(
    // Configuration
    input  wire logic [2:0] filterSel,
    input  wire logic [2:0] modeSel,
    // Decoded result
    output logic      [3:0] laneCount,
    output logic            comboValid
);
    always_comb begin
        laneCount  = 4'h0;
        comboValid = 1'b1;
        case ({filterSel, modeSel})
            {FILT_BYPASS, MODE_FOUR}: laneCount = 4'h4;
            {FILT_BYPASS, MODE_TWO}:  laneCount = 4'h4;
            {FILT_BYPASS, MODE_ONE}:  laneCount = 4'h8;
            {FILT_DEC2, MODE_ONE}:    laneCount = 4'h4;
            {FILT_DEC4IQ, MODE_ONE}:  laneCount = 4'h4;
            {FILT_DEC2, MODE_TWO}:    laneCount = 4'h2;
            {FILT_DEC4IQ, MODE_TWO}:  laneCount = 4'h2;
            {FILT_DEC4, MODE_ONE}:    laneCount = 4'h2;
            {FILT_DEC4, MODE_TWO}:    laneCount = 4'h1;
            default: begin
                // Unlisted pairs report zero lanes and zero the data octets; K characters still go out
                comboValid = 1'b0;
            end
        endcase
    end
endmodule // jlc_lane_decode

/* File: sim/jlc_link_control_assertions.sv */
// Checker for the link control page, bound to its ports
`timescale 1ns/1ps
module jlc_link_control_assertions
    import jlc_pkg::*;
(
    // Clock, reset and APB
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [9:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // Lane side
    input wire logic        syncPin_n,
    input wire logic [7:0]  laneByte,
    input wire logic        laneIsK,
    input wire logic [3:0]  activeLanes,
    input wire logic [4:0]  framesPerMf
);
    // ------------
    // Shadows
    // ------------
    logic [7:0] ctrlSh;
    logic [7:0] syncSh;
    logic [4:0] mfSh;
    logic       warm;
    logic       wr;
    logic       req;
    assign wr = psel && penable && pwrite;
    assign req = syncSh[SYNC_SRC_BIT] ? syncSh[SW_SYNC_BIT] : !syncPin_n;
    // Warm masks the first edge after reset, where lanes still read 0
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlSh <= LINK_CONTROL_RST;
            syncSh <= SYNC_LANE_RST;
            mfSh <= MF_LENGTH_RST;
            warm <= 1'b0;
        end else begin
            warm <= 1'b1;
            if (wr && paddr == LINK_CONTROL_ADDR)
                ctrlSh <= pwdata[7:0] & LINK_CONTROL_MASK;
            if (wr && paddr == SYNC_LANE_ADDR)
                syncSh <= pwdata[7:0];
            if (wr && paddr == MF_LENGTH_ADDR)
                mfSh <= pwdata[4:0];
        end
    end
    function automatic logic [3:0] lanesOf(input logic [5:0] fm);
        case (fm)
            6'h01: lanesOf = 4'h8;
            6'h04, 6'h02, 6'h39, 6'h31: lanesOf = 4'h4;
            6'h32, 6'h21, 6'h3A: lanesOf = 4'h2;
            6'h22: lanesOf = 4'h1;
            default: lanesOf = 4'h0;
        endcase
    endfunction
    // ------------
    // Properties
    // ------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    AST_FRAMES_DEF: assert property (
        !ctrlSh[MF_SRC_BIT] && $stable(ctrlSh) |-> framesPerMf == 5'h05)
        else $error("frames per multiframe not five");
    AST_FRAMES_REG: assert property (
        ctrlSh[MF_SRC_BIT] && $stable(ctrlSh) && $stable(mfSh)
        |-> framesPerMf == mfSh + 5'h01) else $error("frames not field+1");
    // A request reaches the lane after the state and the octet register
    AST_SYNC_PIN: assert property (
        !syncSh[SYNC_SRC_BIT] && !syncPin_n
        |-> ##2 laneIsK && laneByte == K28_5)
        else $error("pin sync request not honoured");
    AST_SYNC_SW: assert property (
        syncSh[7] && syncSh[6] |-> ##2 laneIsK && laneByte == K28_5)
        else $error("register sync request not honoured");
    AST_LANES: assert property (
        warm && $stable(syncSh) |-> activeLanes == lanesOf(syncSh[5:0]))
        else $error("lane count wrong");
    AST_ILA_START: assert property (
        $fell(req) && !ctrlSh[0] |-> ##2 laneIsK && laneByte == 8'h1C)
        else $error("alignment sequence missing");
    AST_ILA_SKIP: assert property (
        $fell(req) && ctrlSh[2:0] == 3'h1 |-> ##2 !laneIsK)
        else $error("alignment sequence not skipped");
    AST_NO_FRAME_K: assert property (
        laneIsK && laneByte == K28_7 |-> $past(ctrlSh[FRAME_ALIGN_BIT]))
        else $error("frame character while disabled");
    AST_SLVERR: assert property (
        psel && penable && paddr > LANE_STATUS_ADDR |-> pslverr)
        else $error("unmapped access without error");
    CV_RELEASE: cover property ($fell(req));
    CV_LANE_K: cover property (laneIsK && laneByte == K28_3);
    CV_ERR: cover property (psel && penable && pslverr);
endmodule // jlc_link_control_assertions
bind jlc_link_control jlc_link_control_assertions i_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .syncPin_n(syncPin_n), .laneByte(laneByte), .laneIsK(laneIsK),
    .activeLanes(activeLanes), .framesPerMf(framesPerMf));

/* File: sim/jlc_rx_model.sv */
// Receiver partner: requests sync, counts alignment characters
`timescale 1ns/1ps
module jlc_rx_model
    import jlc_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Lane stream and bench control
    input  wire logic [7:0] laneByte,
    input  wire logic       laneIsK,
    input  wire logic       holdSync,
    // Sync pin and counts
    output logic            syncPin_n,
    output logic      [7:0] alignCnt,
    output logic      [7:0] frameCnt
);
    logic [2:0] kRun;
    // Pin released after four K28.5 counted, in a row or not; holdSync asks again
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncPin_n <= 1'b0;
            kRun <= 3'h0;
        end else if (holdSync) begin
            syncPin_n <= 1'b0;
            kRun <= 3'h0;
        end else begin
            if (laneIsK && laneByte == K28_5 && kRun < 3'h4)
                kRun <= kRun + 3'h1;
            if (kRun == 3'h4)
                syncPin_n <= 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alignCnt <= 8'h00;
            frameCnt <= 8'h00;
        end else if (!syncPin_n) begin
            // Counts restart with each sync request
            alignCnt <= 8'h00;
            frameCnt <= 8'h00;
        end else begin
            if (laneIsK && laneByte == K28_3)
                alignCnt <= alignCnt + 8'h01;
            if (laneIsK && laneByte == K28_7)
                frameCnt <= frameCnt + 8'h01;
        end
    end
endmodule // jlc_rx_model

/* File: sim/tb_top.sv */
// Self-checking bench for the link control page
`timescale 1ns/1ps
module tb_top
    import jlc_pkg::*;
;
    typedef struct {
        logic [7:0] cfg;
        logic [3:0] lanes;
    } jlc_row_s;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, syncPin_n, laneIsK;
    logic        holdSync = 1'b0;
    logic [13:0] sampleData = 14'h2000;
    logic [7:0]  laneByte, aCnt, fCnt;
    logic [3:0]  activeLanes;
    logic [4:0]  framesPerMf;
    int          n_mismatch = 0, compares = 0, hits;
    jlc_row_s    rows [9] = '{'{8'h04, 4'h4}, '{8'h02, 4'h4}, '{8'h39, 4'h4},
        '{8'h31, 4'h4}, '{8'h32, 4'h2}, '{8'h21, 4'h2}, '{8'h3A, 4'h2},
        '{8'h22, 4'h1}, '{8'h01, 4'h8}};
    always #2 sys_clk = ~sys_clk;
    jlc_link_control #(.SAMPLE_W(14)) i_jlc_link_control (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .sampleData(sampleData),
        .syncPin_n(syncPin_n), .laneByte(laneByte), .laneIsK(laneIsK),
        .activeLanes(activeLanes), .framesPerMf(framesPerMf));
    jlc_rx_model i_jlc_rx_model (
        .sys_clk(sys_clk), .rst_n(rst_n), .laneByte(laneByte),
        .laneIsK(laneIsK), .holdSync(holdSync), .syncPin_n(syncPin_n),
        .alignCnt(aCnt), .frameCnt(fCnt));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic [9:0] a, input logic w,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic scan(input logic [7:0] b, input logic k);
        hits = 0;
        repeat (32) begin
            @(posedge sys_clk);
            if (laneByte === b && laneIsK === k)
                hits++;
        end
    endtask
    // Long wait covers four five-frame multiframes of alignment
    task automatic resync(input logic [7:0] ctl);
        apb(LINK_CONTROL_ADDR, 1'b1, {24'h0, ctl});
        holdSync <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk({laneIsK, laneByte}, {1'b1, K28_5});
        holdSync <= 1'b0;
        repeat (300) @(posedge sys_clk);
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #40000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(activeLanes, 4'h8);
        chk(framesPerMf, 5'h05);
        apb(SYNC_LANE_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h01);
        apb(MF_LENGTH_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h08);
        apb(10'h3FC, 1'b0, 32'h0);
        chk(err, 1'b1);
        // Serializer PLL setting lives outside this block
        foreach (rows[r]) begin
            apb(SYNC_LANE_ADDR, 1'b1, {24'h0, rows[r].cfg});
            repeat (2) @(posedge sys_clk);
            chk(activeLanes, rows[r].lanes);
            apb(SYNC_LANE_ADDR, 1'b0, 32'h0);
            chk(rd, {24'h0, rows[r].cfg});
        end
        apb(MF_LENGTH_ADDR, 1'b1, 32'h0F);
        apb(LINK_CONTROL_ADDR, 1'b1, 32'h80);
        repeat (2) @(posedge sys_clk);
        chk(framesPerMf, 5'h10);
        apb(LINK_CONTROL_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h80);
        resync(8'h00);
        chk(framesPerMf, 5'h05);
        chk(aCnt, 8'h04);
        chk(fCnt, 8'h00);
        scan(8'h80, 1'b0);
        chk(hits > 0, 1'b1);
        apb(LINK_CONTROL_ADDR, 1'b1, 32'h08);
        scan(8'h80, 1'b0);
        chk(hits, 0);
        resync(8'h01);
        chk(aCnt, 8'h00);
        resync(8'h05);
        chk(aCnt > 8'h00, 1'b1);
        resync(8'h03);
        chk(fCnt > 8'h00, 1'b1);
        chk(aCnt, 8'h00);
        sampleData <= 14'h0000;
        apb(LINK_CONTROL_ADDR, 1'b1, 32'h00);
        scan(8'h00, 1'b0);
        chk(hits, 32);
        apb(LINK_CONTROL_ADDR, 1'b1, 32'h10);
        scan(8'h00, 1'b0);
        chk(hits < 32, 1'b1);
        apb(SYNC_LANE_ADDR, 1'b1, 32'hC1);
        // Request passes the state register before the octet register
        @(posedge sys_clk);
        scan(K28_5, 1'b1);
        chk(hits, 32);
        holdSync <= 1'b1;
        apb(SYNC_LANE_ADDR, 1'b1, 32'h41);
        repeat (120) @(posedge sys_clk);
        scan(K28_5, 1'b1);
        chk(hits, 0);
        apb(SYNC_LANE_ADDR, 1'b1, 32'h81);
        @(posedge sys_clk);
        scan(K28_5, 1'b1);
        chk(hits, 32);
        holdSync <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        apb(SYNC_LANE_ADDR, 1'b0, 32'h0);
        chk(rd, 32'h01);
        summarize();
    end
endmodule // tb_top
